/* include/vrz_pkg.sv */
package vrz_pkg;

  localparam int NCH = 4;
  localparam int LVL_W = 8;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  ////////////////////////////////////////////////////////////////////////////
  // register indices, byte address is four times the index
  localparam int IDX_LINE_A = 32'h62;
  localparam int IDX_LINE_B = 32'h63;
  localparam int IDX_PHONES_L = 32'h64;
  localparam int IDX_PHONES_R = 32'h65;
  localparam int IDX_CFG = 32'h88;
  localparam int IDX_OUT_CTRL = 32'h90;
  localparam int IDX_STATUS = 32'h91;

  localparam logic [ADDR_W-1:0] ADDR_LEVEL0 = ADDR_W'(IDX_LINE_A * 4);
  localparam logic [ADDR_W-1:0] ADDR_CFG = ADDR_W'(IDX_CFG * 4);
  localparam logic [ADDR_W-1:0] ADDR_OUT_CTRL = ADDR_W'(IDX_OUT_CTRL * 4);
  localparam logic [ADDR_W-1:0] ADDR_STATUS = ADDR_W'(IDX_STATUS * 4);

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int CFG_ZC_BIT = 0;
  localparam int CFG_SLEW_BIT = 1;
  localparam int CFG_ENH_BIT = 2;
  localparam int OUTC_EN_BIT = 0;
  localparam int STAT_ON_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_DOWN_BIT = 2;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [LVL_W-1:0] LEVEL_RST = 8'h00;
  localparam logic [2:0] CFG_RST = 3'h0;
  localparam logic OUTC_RST = 1'b0;
  localparam logic [LVL_W-1:0] MUTE_CODE = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_KHZ = 250000;
  localparam int TMO_MS = 100;
  localparam int TMO_CYCLES = TMO_MS * CLK_KHZ;
  localparam int STEP_NS = 1000;
  localparam int STEP_CYCLES = (STEP_NS * (CLK_KHZ / 1000) + 999) / 1000;

  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_ON = 3'b010,
    ST_DOWN = 3'b100
  } vrz_state_e;

endpackage

/* include/vrz_ch_if.sv */
`timescale 1ns/1ps
interface vrz_ch_if;
  logic [7:0] target;
  logic zc_en;
  logic slew_en;
  logic enh_en;
  logic force_mute;
  logic step_tick;
  logic zc;
  logic [7:0] gain;
  logic settled;

  modport ctl (
    output target, zc_en, slew_en, enh_en, force_mute, step_tick, zc,
    input gain, settled
  );
  modport ch (
    input target, zc_en, slew_en, enh_en, force_mute, step_tick, zc,
    output gain, settled
  );
endinterface

/* core/vrz_chan.sv */
`timescale 1ns/1ps
module vrz_chan #(
  parameter int TMO_CYCLES = vrz_pkg::TMO_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_b,
  vrz_ch_if.ch chi
);
  import vrz_pkg::*;

  localparam int TW = $clog2(TMO_CYCLES + 1);

  logic [7:0] req;
  logic [7:0] gain;
  logic [TW-1:0] tmr;
  logic [7:0] next_req;
  logic [7:0] next_gain;
  logic [TW-1:0] next_tmr;
  logic [7:0] eff_tgt;
  logic tmo;
  logic apply;

  always_comb begin
    eff_tgt = chi.force_mute ? MUTE_CODE : chi.target;
    tmo = (tmr == TW'(TMO_CYCLES - 1));
    next_req = req;
    if (req != eff_tgt) begin
      if (!chi.slew_en) begin
        next_req = eff_tgt;
      end else if (chi.step_tick && (!chi.enh_en || gain == req)) begin
        // one smallest step toward the target
        next_req = (eff_tgt > req) ? req + 8'h01 : req - 8'h01;
      end
    end
    // held until midpoint crossing or timeout, immediate without detection
    apply = (gain != req) && (!chi.zc_en || chi.zc || tmo);
    next_gain = apply ? req : gain;
    if (apply || gain == req || next_req != req) begin
      next_tmr = '0;
    end else begin
      next_tmr = tmr + TW'(1);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      req <= MUTE_CODE;
      gain <= MUTE_CODE;
      tmr <= '0;
    end else begin
      req <= next_req;
      gain <= next_gain;
      tmr <= next_tmr;
    end
  end

  assign chi.gain = gain;
  assign chi.settled = (gain == eff_tgt) && (req == eff_tgt);

endmodule // vrz_chan

/* core/vrz_top.sv */
`timescale 1ns/1ps
// How it works
// - with midpoint detection on, a gain change waits until the audio crosses its midpoint.
// - a pending change is applied anyway once 100 ms pass without a crossing.
// - every gain stage and output volume control has its own deferred-update channel.
// - with slewing on, the requested level moves one smallest step at a time through every setting.
// - at turn-on with slewing, the level is muted before the output enables, then ramps up.
// - at turn-off with slewing, the level ramps down to mute before the outputs disable.
// - in enhanced mode no new step is requested until the previous one has been applied.
// - in enhanced mode with midpoint detection on, each step lands on a crossing or on the timeout, whichever is first.
// - during a turn-off ramp the enhanced setting is ignored.
module vrz_top #(
  parameter int TMO_CYCLES = vrz_pkg::TMO_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [vrz_pkg::ADDR_W-1:0] paddr,
  input wire logic [vrz_pkg::DATA_W-1:0] pwdata,
  output logic [vrz_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [vrz_pkg::NCH-1:0] zc_det,
  output logic [vrz_pkg::NCH-1:0][vrz_pkg::LVL_W-1:0] gain_code,
  output logic out_en
);
  import vrz_pkg::*;

  localparam int SW = $clog2(STEP_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////////////
  // register file

  logic [NCH-1:0][LVL_W-1:0] level;
  logic [2:0] cfg;
  logic outc_en;
  logic [DATA_W-1:0] rdata;
  logic [NCH-1:0][LVL_W-1:0] next_level;
  logic [2:0] next_cfg;
  logic next_outc_en;
  logic [DATA_W-1:0] next_rdata;
  logic setup;
  logic wr;
  logic hit;
  logic [DATA_W-1:0] rd_mux;

  vrz_state_e state;
  vrz_state_e next_state;
  logic [NCH-1:0] settled;
  logic all_settled;

  always_comb begin
    hit = 1'b0;
    rd_mux = '0;
    for (int i = 0; i < NCH; i++) begin
      if (paddr == ADDR_LEVEL0 + ADDR_W'(i * 4)) begin
        hit = 1'b1;
        rd_mux = {24'h000000, level[i]};
      end
    end
    if (paddr == ADDR_CFG) begin
      hit = 1'b1;
      rd_mux = {29'h0, cfg};
    end
    if (paddr == ADDR_OUT_CTRL) begin
      hit = 1'b1;
      rd_mux = {31'h0, outc_en};
    end
    if (paddr == ADDR_STATUS) begin
      hit = 1'b1;
      rd_mux = '0;
      rd_mux[STAT_ON_BIT] = out_en;
      rd_mux[STAT_BUSY_BIT] = ~all_settled;
      rd_mux[STAT_DOWN_BIT] = (state == ST_DOWN);
    end
  end

  // zero-wait slave: read data is captured in the setup cycle
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && hit;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  always_comb begin
    next_level = level;
    next_cfg = cfg;
    next_outc_en = outc_en;
    next_rdata = rdata;
    if (setup && !pwrite) begin
      next_rdata = rd_mux;
    end
    if (wr) begin
      for (int i = 0; i < NCH; i++) begin
        if (paddr == ADDR_LEVEL0 + ADDR_W'(i * 4)) begin
          next_level[i] = pwdata[LVL_W-1:0];
        end
      end
      if (paddr == ADDR_CFG) begin
        next_cfg = pwdata[2:0];
      end
      if (paddr == ADDR_OUT_CTRL) begin
        next_outc_en = pwdata[OUTC_EN_BIT];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      level <= {NCH{LEVEL_RST}};
      cfg <= CFG_RST;
      outc_en <= OUTC_RST;
      rdata <= '0;
    end else begin
      level <= next_level;
      cfg <= next_cfg;
      outc_en <= next_outc_en;
      rdata <= next_rdata;
    end
  end

  assign prdata = rdata;

  ////////////////////////////////////////////////////////////////////////////
  // step pacing

  logic [SW-1:0] step_cnt;
  logic [SW-1:0] next_step_cnt;
  logic step_tick;

  always_comb begin
    step_tick = (step_cnt == SW'(STEP_CYCLES - 1));
    next_step_cnt = step_tick ? '0 : step_cnt + SW'(1);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      step_cnt <= '0;
    end else begin
      step_cnt <= next_step_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output power sequencer

  logic force_mute;
  logic enh_eff;

  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: begin
        // with slewing on, enable only once every channel sits at mute; without it, enable at once
        if (outc_en && (!cfg[CFG_SLEW_BIT] || all_settled)) begin
          next_state = ST_ON;
        end
      end
      ST_ON: begin
        if (!outc_en) begin
          next_state = cfg[CFG_SLEW_BIT] ? ST_DOWN : ST_OFF;
        end
      end
      ST_DOWN: begin
        if (all_settled) begin
          next_state = ST_OFF;
        end
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  assign out_en = (state == ST_ON) || (state == ST_DOWN);
  assign force_mute = (state != ST_ON);
  assign enh_eff = cfg[CFG_ENH_BIT] && (state != ST_DOWN);
  assign all_settled = &settled;

  ////////////////////////////////////////////////////////////////////////////
  // one deferred-update channel per gain stage

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    vrz_ch_if chi ();

    assign chi.target = level[g];
    assign chi.zc_en = cfg[CFG_ZC_BIT];
    assign chi.slew_en = cfg[CFG_SLEW_BIT];
    assign chi.enh_en = enh_eff;
    assign chi.force_mute = force_mute;
    assign chi.step_tick = step_tick;
    assign chi.zc = zc_det[g];

    vrz_chan #(
      .TMO_CYCLES(TMO_CYCLES)
    ) u_chan (
      .mclk(mclk),
      .rst_b(rst_b),
      .chi(chi.ch)
    );

    assign gain_code[g] = chi.gain;
    assign settled[g] = chi.settled;
  end

endmodule // vrz_top

/* tb/vrz_top_asserts.sv */
`timescale 1ns/1ps
module vrz_top_chk #(
  parameter int TMO_CYCLES = 50
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [vrz_pkg::ADDR_W-1:0] paddr,
  input wire logic [vrz_pkg::DATA_W-1:0] pwdata,
  input wire logic [vrz_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [vrz_pkg::NCH-1:0] zc_det,
  input wire logic [vrz_pkg::NCH-1:0][vrz_pkg::LVL_W-1:0] gain_code,
  input wire logic out_en
);
  import vrz_pkg::*;
  logic [2:0] cfg;
  logic [7:0] g0;
  int quiet;
  wire logic wr0 = psel && penable && pwrite && paddr == ADDR_LEVEL0;
  // shadow of the config register and cycles since channel 0 last moved
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cfg <= '0;
      g0 <= '0;
      quiet <= 0;
    end else begin
      if (psel && penable && pwrite && paddr == ADDR_CFG) cfg <= pwdata[2:0];
      g0 <= gain_code[0];
      quiet <= (gain_code[0] != g0) ? 0 : quiet + 1;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  chk_mute_on: assert property ($rose(out_en) && cfg[1] |-> gain_code == '0)
    else $error("enabled unmuted");
  chk_mute_off: assert property ($fell(out_en) && cfg[1] |-> gain_code == '0)
    else $error("disabled unmuted");
  chk_slew_step: assert property (
    cfg == 3'h2 && out_en && $past(out_en) && $changed(gain_code[0])
    |-> 8'(gain_code[0] - $past(gain_code[0])) inside {8'h01, 8'hff})
    else $error("step not one");
  chk_direct_level: assert property (
    wr0 && cfg == 3'h0 && out_en |-> ##3 gain_code[0] == $past(pwdata[7:0], 3))
    else $error("level late");
  chk_zc_wait: assert property (wr0 && cfg == 3'h1 ##1 !zc_det[0] [*6] |=> $stable(gain_code[0]))
    else $error("no crossing wait");
  chk_enh_cross: assert property (
    cfg == 3'h7 && gain_code[0] > $past(gain_code[0])
    |-> $past(zc_det[0]) || $past(zc_det[0], 2) || quiet >= TMO_CYCLES - 2)
    else $error("step unprompted");
  chk_err_phase: assert property (pslverr |-> psel && penable && paddr != ADDR_CFG)
    else $error("stray error");
  chk_cfg_read: assert property (
    psel && !penable && !pwrite && paddr == ADDR_CFG |=> prdata == {29'h0, cfg})
    else $error("cfg read wrong");
  cov_on: cover property ($rose(out_en) && cfg[1]);
  cov_off: cover property ($fell(out_en) && cfg[1]);
  cov_enh: cover property (cfg == 3'h7 && $changed(gain_code[0]));
endmodule // vrz_top_chk

bind vrz_top vrz_top_chk #(.TMO_CYCLES(TMO_CYCLES)) u_chk (.mclk(mclk), .rst_b(rst_b),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .zc_det(zc_det),
  .gain_code(gain_code), .out_en(out_en));

/* tb/vrz_top_tb_top.sv */
`timescale 1ns/1ps
module vrz_top_tb_top;
  import vrz_pkg::*;
  logic mclk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, out_en, er;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0, prdata, rd;
  logic [NCH-1:0] zc_det = '0;
  logic [NCH-1:0][LVL_W-1:0] gain_code;
  int err_count = 0, num_checks = 0, cyc = 0, n;
  vrz_top #(.TMO_CYCLES(600)) uut (.mclk(mclk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .zc_det(zc_det), .gain_code(gain_code),
    .out_en(out_en));
  initial begin
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      results();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  // one apb transfer, then one idle cycle so calls can follow each other
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge mclk);
  endtask
  // channel index NCH waits on out_en instead
  task automatic waitg(input int c, input logic [7:0] v);
    n = 0;
    while ((c < NCH ? gain_code[c] : 8'(out_en)) !== v) begin
      @(posedge mclk);
      n++;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge mclk);
    rst_b <= 1;
    @(posedge mclk);
    for (int i = 0; i < 4; i++) begin
      apb(0, ADDR_LEVEL0 + 12'(4 * i), 0);
      cmp("level rst", 0, rd);
    end
    apb(0, ADDR_CFG, 0);
    cmp("cfg rst", 0, rd);
    apb(1, 12'h004, 1);
    cmp("unmapped", 1, er);
    $display("reset done");
    apb(1, ADDR_OUT_CTRL, 1);
    for (int i = 0; i < 4; i++) begin
      apb(1, ADDR_LEVEL0 + 12'(4 * i), 32'h10 + i);
      repeat (3) @(posedge mclk);
      cmp("direct", 32'h10 + i, gain_code[i]);
    end
    $display("direct done");
    apb(1, ADDR_CFG, 1);
    apb(1, ADDR_LEVEL0, 32'h40);
    repeat (20) @(posedge mclk);
    cmp("zc hold", 32'h10, gain_code[0]);
    zc_det <= 4'h1;
    @(posedge mclk);
    zc_det <= 4'h0;
    repeat (3) @(posedge mclk);
    cmp("zc apply", 32'h40, gain_code[0]);
    apb(1, ADDR_LEVEL0 + 12'h4, 32'h41);
    repeat (570) @(posedge mclk);
    cmp("tmo hold", 32'h11, gain_code[1]);
    repeat (40) @(posedge mclk);
    cmp("tmo apply", 32'h41, gain_code[1]);
    $display("crossing done");
    apb(1, ADDR_CFG, 2);
    apb(1, ADDR_OUT_CTRL, 0);
    waitg(1, 0);
    cmp("ramp down", 1, n >= 16000);
    cmp("held on", 1, out_en);
    for (int i = 0; i < 4; i++) apb(1, ADDR_LEVEL0 + 12'(4 * i), 3);
    apb(1, ADDR_OUT_CTRL, 1);
    waitg(NCH, 1);
    cmp("mute at on", 0, gain_code);
    waitg(0, 3);
    cmp("ramp up", 1, n >= 500);
    $display("slew done");
    apb(1, ADDR_CFG, 7);
    apb(0, ADDR_CFG, 0);
    cmp("cfg rd", 7, rd);
    apb(1, ADDR_LEVEL0, 6);
    repeat (1000) @(posedge mclk);
    cmp("enh one", 4, gain_code[0]);
    repeat (80) begin
      zc_det <= 4'hf;
      @(posedge mclk);
      zc_det <= 4'h0;
      repeat (9) @(posedge mclk);
    end
    cmp("enh zc", 6, gain_code[0]);
    apb(0, ADDR_STATUS, 0);
    cmp("status on", 1, rd);
    apb(1, ADDR_OUT_CTRL, 0);
    apb(0, ADDR_STATUS, 0);
    cmp("status down", 7, rd);
    waitg(NCH, 0);
    cmp("down fast", 1, n < 2400);
    cmp("mute at off", 0, gain_code);
    $display("enhanced done");
    results();
  end
endmodule // vrz_top_tb_top
